// >>> fault_cfg.svh
// command codes, field positions, reset values and timing counts for the
// fault response block; included by every design file that needs them
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH

// command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_ALERT_MASK 8'h1B
`define CMD_UV_ACTION 8'h45
`define CMD_OC_ACTION 8'h47
`define CMD_TON_ACTION 8'h63
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_STATUS_VOUT 8'h7A
`define CMD_RETRY_IVL 8'hF5

// fields of a fault response byte
`define RESP_HI 7
`define RESP_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DELAY_HI 2
`define DELAY_LO 0
`define RESP_IGNORE 2'h0
`define RESP_DEGLITCH 2'h1
`define RESP_SHUTDOWN 2'h2
`define RESP_BAD 2'h3
`define RETRY_FOREVER 3'h7

// status bit positions
`define SB_NONE_BIT 0
`define SB_CML_BIT 1
`define SW_VOUT_BIT 15
`define SV_UV_BIT 4
`define SV_TON_BIT 2

// alert mask bits
`define MASK_UV_BIT 0
`define MASK_TON_BIT 1
`define MASK_CML_BIT 2

// reset values
`define UV_ACTION_RST 8'h00
`define OC_ACTION_RST 8'h00
`define TON_ACTION_RST 8'h80
`define RETRY_IVL_RST 8'h0A
`define ALERT_MASK_RST 8'h00

// timing
`define TICK_US 10
`define CLK_MHZ 250
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

`endif

// >>> fault_pkg.sv
// types shared by the fault response design files
// assumes nothing beyond a SystemVerilog compiler
package fault_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {UV_IDLE, UV_DEGLITCH, UV_OFF, UV_RETRY} uv_state_t;
endpackage

// >>> tick_gen.sv
// free running timebase: one pulse every CYCLES enabled clocks
// assumes clk is the core clock and ce the block-wide clock enable
`timescale 1ns/1ns
module tick_gen #(
  parameter int CYCLES = 2500
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  if (CYCLES < 2) begin : g_chk
    $error("tick_gen needs CYCLES of at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic wrap;

  assign wrap = (cnt_q == LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick <= wrap;
    end
  end
endmodule

// >>> word_crossing.sv
// moves one word from a source clock domain to a destination domain
// with a toggle handshake; the source holds busy until the return
// toggle has come back, so its data register is stable while sampled
`timescale 1ns/1ns
module word_crossing #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_srst,
  input wire logic src_ce,
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_srst,
  input wire logic dst_ce,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  if (W < 1) begin : g_chk
    $error("word_crossing needs W of at least 1");
  end

  logic req_q;
  logic [W-1:0] hold_q;
  logic a1_q, a2_q, a3_q, ack_q;
  logic r1_q, r2_q, r3_q, seen_q;
  logic new_req;

  assign src_busy = (req_q != ack_q);
  // a change counts only once the second and third stages agree
  assign new_req = (r2_q == r3_q) && (r3_q != seen_q);

  always_ff @(posedge src_clk) begin
    if (src_srst) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (src_ce && src_valid && !src_busy) begin
      req_q <= ~req_q;
      hold_q <= src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_srst) begin
      {a1_q, a2_q, a3_q, ack_q} <= 4'h0;
    end else if (src_ce) begin
      a1_q <= seen_q;
      a2_q <= a1_q;
      a3_q <= a2_q;
      if (a2_q == a3_q) ack_q <= a3_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_srst) begin
      {r1_q, r2_q, r3_q, seen_q, dst_valid} <= 5'h00;
      dst_data <= '0;
    end else if (dst_ce) begin
      r1_q <= req_q;
      r2_q <= r1_q;
      r3_q <= r2_q;
      dst_valid <= new_req;
      if (new_req) begin
        seen_q <= r3_q;
        dst_data <= hold_q;
      end
    end
  end
endmodule

// >>> fault_response_policy.sv
// undervoltage and turn-on-timeout fault response for one output channel
// assumes a command link on link_clk delivering decoded command bytes and
// regulator status levels on clk; uv_detect and run_control_pin are async
//
// What this block does
// - response 00: output keeps running, undervoltage fault has no functional effect
// - response 01: run for programmed delay, then act per retry field if fault persists
// - response 10: disable output at once, then follow retry field
// - writing response 11 to the undervoltage response byte raises the comm/memory/logic fault
// - retry 000 to 110: stay off until cleared, commanded off or bias lost
// - retry 111: restart forever at retry interval until off or non-retry fault
// - delay field counts 10 us steps, used only for deglitched shutdown
// - every response sets its status bit and alerts the host unless masked
// - fault bits stay latched until clear faults or another clearing event
// - turning the output off then on clears latched fault bits
// - turn-on timeout sets none-of-above, vout word bit, timeout bit, alert
// - turn-on timeout response of zero disables that response
// - each fault response command carries exactly one data byte
// - overcurrent response byte at 0x47, read/write, default 0x00
// - undervoltage detection is masked while the channel is inactive
// - undervoltage detection is masked during rise and fall sequencing
// - undervoltage fault sets vout word bit and undervoltage bit
`timescale 1ns/1ns
`include "fault_cfg.svh"
module fault_response_policy #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_srst,
  input wire logic wr_valid,
  input wire fault_pkg::byte_t wr_code,
  input wire fault_pkg::byte_t wr_data,
  input wire logic [2:0] wr_count,
  input wire logic rd_valid,
  input wire fault_pkg::byte_t rd_code,
  output logic link_busy,
  output logic rd_done,
  output fault_pkg::word_t rd_data,
  input wire logic uv_detect,
  input wire logic run_control_pin,
  input wire logic operation_on,
  input wire logic chan_active,
  input wire logic rise_active,
  input wire logic fall_active,
  input wire logic ton_max_fault,
  output logic output_enable,
  output logic alert_o,
  output logic alert_oe,
  output fault_pkg::byte_t oc_action,
  output fault_pkg::uv_state_t uv_state
);
  import fault_pkg::*;

  localparam int REQ_W = 20;

  // link domain
  logic req_busy;
  logic rd_wait_q;
  logic link_take;
  logic take_rd;
  logic [REQ_W-1:0] req_word;

  // a write offered together with a read wins; the read is dropped
  assign take_rd = rd_valid && !wr_valid;
  assign link_take = (wr_valid || rd_valid) && !link_busy;
  assign link_busy = req_busy || rd_wait_q;
  assign req_word = take_rd ? {1'b1, rd_code, 8'h00, 3'h0} : {1'b0, wr_code, wr_data, wr_count};

  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      rd_wait_q <= 1'b0;
    end else if (link_take && take_rd) begin
      rd_wait_q <= 1'b1;
    end else if (rd_done) begin
      rd_wait_q <= 1'b0;
    end
  end

  // crossings
  logic req_valid;
  logic [REQ_W-1:0] req_q;
  logic ans_send;
  word_t ans_word;

  word_crossing #(.W(REQ_W)) u_req (
    .src_clk(link_clk),
    .src_srst(link_srst),
    .src_ce(1'b1),
    .src_valid(link_take),
    .src_data(req_word),
    .src_busy(req_busy),
    .dst_clk(clk),
    .dst_srst(srst),
    .dst_ce(ce),
    .dst_valid(req_valid),
    .dst_data(req_q)
  );

  word_crossing #(.W(16)) u_ans (
    .src_clk(clk),
    .src_srst(srst),
    .src_ce(ce),
    .src_valid(ans_send),
    .src_data(ans_word),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_srst(link_srst),
    .dst_ce(1'b1),
    .dst_valid(rd_done),
    .dst_data(rd_data)
  );

  // core domain
  logic tick;

  tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tick(tick)
  );

  // three stage synchronisers for the two asynchronous inputs
  logic [1:0] pin_raw;
  logic [1:0] s1_q, s2_q, s3_q, pin_q;

  assign pin_raw = {run_control_pin, uv_detect};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        {s1_q[i], s2_q[i], s3_q[i], pin_q[i]} <= 4'h0;
      end else if (ce) begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
    end
  end

  // command decode
  logic is_rd;
  byte_t cmd_code, cmd_data;
  logic [2:0] cmd_count;
  logic one_byte, wr_req, rd_req;
  logic wr_uv, wr_oc, wr_ton, wr_retry, wr_mask, clear_cmd;
  logic known_byte, bad_resp, cml_set;

  assign {is_rd, cmd_code, cmd_data, cmd_count} = req_q;
  assign wr_req = req_valid && !is_rd;
  assign rd_req = req_valid && is_rd;
  assign one_byte = (cmd_count == 3'h1);
  assign known_byte = (cmd_code == `CMD_UV_ACTION) || (cmd_code == `CMD_OC_ACTION)
    || (cmd_code == `CMD_TON_ACTION) || (cmd_code == `CMD_RETRY_IVL)
    || (cmd_code == `CMD_ALERT_MASK);
  assign bad_resp = (cmd_data[`RESP_HI:`RESP_LO] == `RESP_BAD);
  assign wr_uv = wr_req && one_byte && (cmd_code == `CMD_UV_ACTION) && !bad_resp;
  assign wr_oc = wr_req && one_byte && (cmd_code == `CMD_OC_ACTION);
  assign wr_ton = wr_req && one_byte && (cmd_code == `CMD_TON_ACTION);
  assign wr_retry = wr_req && one_byte && (cmd_code == `CMD_RETRY_IVL);
  assign wr_mask = wr_req && one_byte && (cmd_code == `CMD_ALERT_MASK);
  assign clear_cmd = wr_req && (cmd_count == 3'h0) && (cmd_code == `CMD_CLEAR_FAULTS);
  // wrong byte count, unsupported response or unknown command
  assign cml_set = wr_req && ((known_byte && !one_byte)
    || (cmd_code == `CMD_UV_ACTION && bad_resp)
    || (!known_byte && !(cmd_code == `CMD_CLEAR_FAULTS && cmd_count == 3'h0)));

  // stored command bytes
  byte_t uv_action_q, ton_action_q, retry_ivl_q, mask_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      uv_action_q <= `UV_ACTION_RST;
      oc_action <= `OC_ACTION_RST;
      ton_action_q <= `TON_ACTION_RST;
      retry_ivl_q <= `RETRY_IVL_RST;
      mask_q <= `ALERT_MASK_RST;
    end else if (ce) begin
      if (wr_uv) uv_action_q <= cmd_data;
      if (wr_oc) oc_action <= cmd_data;
      if (wr_ton) ton_action_q <= cmd_data;
      if (wr_retry) retry_ivl_q <= cmd_data;
      if (wr_mask) mask_q <= cmd_data;
    end
  end

  // response fields
  logic [1:0] resp;
  logic [2:0] retry, delay;

  assign resp = uv_action_q[`RESP_HI:`RESP_LO];
  assign retry = uv_action_q[`RETRY_HI:`RETRY_LO];
  assign delay = uv_action_q[`DELAY_HI:`DELAY_LO];

  // on/off control and clearing events
  logic on_req, on_prev_q, on_rise, clear_ev;
  logic uv_seen, uv_set, ton_set;
  logic st_uv_q, st_ton_q, st_cml_q, ton_shut_q;

  assign on_req = pin_q[1] && operation_on;
  assign on_rise = on_req && !on_prev_q;
  assign clear_ev = clear_cmd || on_rise;
  assign uv_seen = pin_q[0] && chan_active && !rise_active && !fall_active;
  assign uv_set = (uv_state == UV_IDLE) && uv_seen && output_enable;
  assign ton_set = ton_max_fault && (ton_action_q != 8'h00);

  // latched fault bits; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      {on_prev_q, st_uv_q, st_ton_q, st_cml_q, ton_shut_q} <= 5'h00;
    end else if (ce) begin
      on_prev_q <= on_req;
      st_uv_q <= uv_set || (st_uv_q && !clear_ev);
      st_ton_q <= ton_set || (st_ton_q && !clear_ev);
      st_cml_q <= cml_set || (st_cml_q && !clear_ev);
      ton_shut_q <= ton_set || (ton_shut_q && !clear_ev);
    end
  end

  // undervoltage response sequencer
  uv_state_t state_d;
  byte_t cnt_q, cnt_d;
  logic act_now;

  // deglitched response acts at once when its delay field is zero
  assign act_now = (resp == `RESP_SHUTDOWN) || (resp == `RESP_DEGLITCH && delay == 3'h0);

  always_comb begin
    state_d = uv_state;
    cnt_d = cnt_q;
    unique case (uv_state)
      UV_IDLE: begin
        if (uv_set && act_now) begin
          state_d = UV_OFF;
        end else if (uv_set && resp == `RESP_DEGLITCH) begin
          state_d = UV_DEGLITCH;
          cnt_d = {5'h00, delay};
        end
      end
      UV_DEGLITCH: begin
        if (!uv_seen || !on_req) begin
          state_d = UV_IDLE;
        end else if (tick && cnt_q == 8'h01) begin
          state_d = UV_OFF;
        end else if (tick) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      UV_OFF: begin
        if (!on_req || clear_cmd) begin
          state_d = UV_IDLE;
        end else if (retry == `RETRY_FOREVER && !ton_shut_q) begin
          state_d = UV_RETRY;
          cnt_d = retry_ivl_q;
        end
      end
      UV_RETRY: begin
        if (!on_req) begin
          state_d = UV_IDLE;
        end else if (ton_shut_q) begin
          state_d = UV_OFF;
        end else if (tick && cnt_q == 8'h00) begin
          state_d = UV_IDLE;
        end else if (tick) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
  end

  // the 10 us tick is free running, so the first step of a delay can be
  // short by up to one tick; cheaper than restarting the timebase per fault
  always_ff @(posedge clk) begin
    if (srst) begin
      uv_state <= UV_IDLE;
      cnt_q <= 8'h00;
      output_enable <= 1'b0;
    end else if (ce) begin
      uv_state <= state_d;
      cnt_q <= cnt_d;
      output_enable <= on_req && !ton_shut_q
        && (state_d == UV_IDLE || state_d == UV_DEGLITCH);
    end
  end

  // status views and read answers
  byte_t status_byte, status_vout;
  word_t status_word;
  logic alert_q;

  assign status_byte = {6'h00, st_cml_q, st_ton_q};
  assign status_vout = {3'h0, st_uv_q, 1'b0, st_ton_q, 2'h0};
  assign status_word = {st_uv_q || st_ton_q, 7'h00, status_byte};
  assign ans_send = rd_req;
  assign ans_word =
    (cmd_code == `CMD_UV_ACTION) ? {8'h00, uv_action_q} :
    (cmd_code == `CMD_OC_ACTION) ? {8'h00, oc_action} :
    (cmd_code == `CMD_TON_ACTION) ? {8'h00, ton_action_q} :
    (cmd_code == `CMD_RETRY_IVL) ? {8'h00, retry_ivl_q} :
    (cmd_code == `CMD_ALERT_MASK) ? {8'h00, mask_q} :
    (cmd_code == `CMD_STATUS_BYTE) ? {8'h00, status_byte} :
    (cmd_code == `CMD_STATUS_VOUT) ? {8'h00, status_vout} :
    (cmd_code == `CMD_STATUS_WORD) ? status_word : 16'h0000;

  // open drain alert: only ever pulls low
  always_ff @(posedge clk) begin
    if (srst) begin
      alert_q <= 1'b0;
    end else if (ce) begin
      alert_q <= (st_uv_q && !mask_q[`MASK_UV_BIT])
        || (st_ton_q && !mask_q[`MASK_TON_BIT])
        || (st_cml_q && !mask_q[`MASK_CML_BIT]);
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = alert_q;

  // checks
  sequence s_deglitch_start;
    ce && uv_state == UV_IDLE && uv_set && resp == `RESP_DEGLITCH && delay != 3'h0;
  endsequence

  sequence s_in_deglitch;
    uv_state == UV_DEGLITCH && cnt_q == {5'h00, $past(delay)};
  endsequence

  a_ignore_keeps_run: assert property (@(posedge clk) disable iff (srst)
    (ce && uv_set && resp == `RESP_IGNORE) |=> uv_state == UV_IDLE)
    else $error("ignore response left idle");

  a_deglitch_entry: assert property (@(posedge clk) disable iff (srst)
    s_deglitch_start |=> s_in_deglitch)
    else $error("deglitch did not load the delay");

  a_shutdown_now: assert property (@(posedge clk) disable iff (srst)
    (ce && uv_set && resp == `RESP_SHUTDOWN) |=> (uv_state == UV_OFF && !output_enable))
    else $error("shutdown response kept the output on");

  a_bad_resp_cml: assert property (@(posedge clk) disable iff (srst)
    (ce && wr_req && cmd_code == `CMD_UV_ACTION && bad_resp)
    |=> (st_cml_q && uv_action_q == $past(uv_action_q)))
    else $error("unsupported response not refused");

  a_no_retry_hold: assert property (@(posedge clk) disable iff (srst)
    (ce && uv_state == UV_OFF && retry != `RETRY_FOREVER && on_req && !clear_cmd)
    |=> (uv_state == UV_OFF && !output_enable))
    else $error("output restarted without retry");

  a_retry_loop: assert property (@(posedge clk) disable iff (srst)
    (ce && uv_state == UV_OFF && retry == `RETRY_FOREVER && on_req && !ton_shut_q
    && !clear_cmd) |=> (uv_state == UV_RETRY && cnt_q == $past(retry_ivl_q)))
    else $error("retry did not start");

  a_flag_latched: assert property (@(posedge clk) disable iff (srst)
    (ce && st_uv_q && !clear_ev) |=> st_uv_q)
    else $error("undervoltage bit dropped without a clear");

  a_off_on_clears: assert property (@(posedge clk) disable iff (srst)
    (ce && on_rise && !uv_set) |=> !st_uv_q)
    else $error("off then on did not clear the bit");

  a_alert_follows: assert property (@(posedge clk) disable iff (srst)
    (ce && st_uv_q && !mask_q[`MASK_UV_BIT]) |=> alert_oe)
    else $error("alert not raised");

  a_ton_status: assert property (@(posedge clk) disable iff (srst)
    (ce && ton_max_fault && ton_action_q != 8'h00)
    |=> (status_word[`SW_VOUT_BIT] && status_byte[`SB_NONE_BIT] && status_vout[`SV_TON_BIT]))
    else $error("timeout status bits missing");

  a_ton_zero_off: assert property (@(posedge clk) disable iff (srst)
    (ce && ton_max_fault && ton_action_q == 8'h00 && !st_ton_q) |=> !st_ton_q)
    else $error("disabled timeout response still flagged");

  a_uv_masked: assert property (@(posedge clk) disable iff (srst)
    (!chan_active || rise_active || fall_active) |-> !uv_set)
    else $error("undervoltage seen while masked");

  a_abandon_clean: assert property (@(posedge clk) disable iff (srst)
    (ce && uv_state == UV_DEGLITCH && !uv_seen)
    |=> (uv_state == UV_IDLE && output_enable == $past(on_req && !ton_shut_q)))
    else $error("deglitch acted after the fault went away");
endmodule

// >>> pmbus_host.sv
// behavioural command-link host: issues writes and reads one at a time
// assumes the block's link port timing; requests change at link_clk falling edges
`timescale 1ns/1ns
module pmbus_host (
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic rd_done,
  input wire fault_pkg::word_t rd_data,
  output logic wr_valid,
  output fault_pkg::byte_t wr_code,
  output fault_pkg::byte_t wr_data,
  output logic [2:0] wr_count,
  output logic rd_valid,
  output fault_pkg::byte_t rd_code,
  output logic timed_out
);
  import fault_pkg::*;
  initial begin
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_code = 8'h00;
    wr_data = 8'h00;
    wr_count = 3'h0;
    rd_code = 8'h00;
    timed_out = 1'b0;
  end
  task automatic wait_idle();
    int n;
    n = 0;
    while (link_busy !== 1'b0 && n < 100) begin
      @(negedge link_clk);
      n++;
    end
    if (n >= 100) begin
      timed_out = 1'b1;
      $display("ERROR %0t link stayed busy", $time);
    end
  endtask
  task automatic send(input logic w, input byte_t c, input byte_t d, input logic [2:0] cnt);
    @(negedge link_clk);
    wait_idle();
    wr_valid = w;
    rd_valid = ~w;
    wr_code = c;
    rd_code = c;
    wr_data = d;
    wr_count = cnt;
    @(negedge link_clk);
    // released code and data lines carry the inverse so stale values cannot pass for fresh ones
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_code = ~c;
    rd_code = ~c;
    wr_data = ~d;
  endtask
  task automatic write(input byte_t c, input byte_t d, input logic [2:0] cnt);
    send(1'b1, c, d, cnt);
    wait_idle();
  endtask
  task automatic read(input byte_t c, output word_t v);
    int n;
    n = 0;
    send(1'b0, c, 8'h00, 3'h0);
    while (rd_done !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    if (n >= 40) begin
      timed_out = 1'b1;
      $display("ERROR %0t read answer missing", $time);
    end
    v = rd_data;
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the fault response block
// assumes the host model above and a shortened 10 us tick
`timescale 1ns/1ns
`include "fault_cfg.svh"
module testbench;
  import fault_pkg::*;
  localparam int TICK = 8;
  logic clk, srst, link_clk, link_srst, uv_detect, run_control_pin, operation_on;
  logic chan_active, rise_active, fall_active, ton_max_fault;
  logic wr_valid, rd_valid, link_busy, rd_done, output_enable, alert_o, alert_oe, timed_out;
  byte_t wr_code, wr_data, rd_code, oc_action;
  logic [2:0] wr_count;
  word_t rd_data;
  uv_state_t uv_state;
  int n_errors = 0;
  int n_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // unrelated phase to clk: starts 1 ns late
  initial begin
    link_clk = 1'b0;
    #1;
    forever begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end
  fault_response_policy #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .srst(srst), .ce(1'b1),
    .link_clk(link_clk), .link_srst(link_srst), .wr_valid(wr_valid), .wr_code(wr_code),
    .wr_data(wr_data), .wr_count(wr_count), .rd_valid(rd_valid), .rd_code(rd_code),
    .link_busy(link_busy), .rd_done(rd_done), .rd_data(rd_data), .uv_detect(uv_detect),
    .run_control_pin(run_control_pin), .operation_on(operation_on),
    .chan_active(chan_active), .rise_active(rise_active), .fall_active(fall_active),
    .ton_max_fault(ton_max_fault), .output_enable(output_enable), .alert_o(alert_o),
    .alert_oe(alert_oe), .oc_action(oc_action), .uv_state(uv_state));
  pmbus_host i_host (.link_clk(link_clk), .link_busy(link_busy), .rd_done(rd_done),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_code(wr_code), .wr_data(wr_data),
    .wr_count(wr_count), .rd_valid(rd_valid), .rd_code(rd_code), .timed_out(timed_out));
  task automatic chk(input word_t got, input word_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input byte_t c, input byte_t d);
    i_host.write(c, d, 3'h1);
    cyc(4);
  endtask
  task automatic rdchk(input byte_t c, input word_t e, input string w);
    word_t v;
    i_host.read(c, v);
    // back onto a falling clk edge so later core-side stimulus does not race clk
    cyc(1);
    chk(v, e, w);
  endtask
  task automatic rdbit(input byte_t c, input int b, input logic e, input string w);
    word_t v;
    i_host.read(c, v);
    cyc(1);
    chk(word_t'(v[b]), word_t'(e), w);
  endtask
  task automatic clr();
    i_host.write(`CMD_CLEAR_FAULTS, 8'h00, 3'h0);
    cyc(8);
  endtask
  task automatic wait_oe(input logic v, input int n);
    int k;
    k = 0;
    while (output_enable !== v && k < n) begin
      cyc(1);
      k++;
    end
    chk(word_t'(output_enable), word_t'(v), "output enable");
  endtask
  task automatic restart(input logic by_pin);
    if (by_pin) run_control_pin = 1'b0;
    else operation_on = 1'b0;
    cyc(8);
    run_control_pin = 1'b1;
    operation_on = 1'b1;
    wait_oe(1'b1, 20);
  endtask
  task automatic print_verdict();
    if (timed_out === 1'b1) n_errors++;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    $display("ERROR %0t run did not finish", $time);
    print_verdict();
  end
  initial begin
    {srst, link_srst} = 2'b11;
    {uv_detect, run_control_pin, operation_on, chan_active} = 4'h0;
    {rise_active, fall_active, ton_max_fault} = 3'h0;
    // both resets overlap for at least one edge of each clock
    repeat (4) @(negedge clk);
    @(negedge clk) srst = 1'b0;
    @(negedge link_clk) link_srst = 1'b0;
    cyc(8);
    chk(word_t'(output_enable), 16'h0000, "oe after reset");
    chk(word_t'(alert_oe), 16'h0000, "alert after reset");
    chk(word_t'(alert_o), 16'h0000, "alert data low");
    chk(word_t'(oc_action), 16'h0000, "oc after reset");
    chk(word_t'(uv_state), word_t'(UV_IDLE), "state after reset");
    {run_control_pin, operation_on, chan_active} = 3'b111;
    wait_oe(1'b1, 20);
    rdchk(`CMD_OC_ACTION, 16'h0000, "oc default");
    wr(`CMD_OC_ACTION, 8'hA5);
    chk(word_t'(oc_action), 16'h00A5, "oc stored");
    rdchk(`CMD_OC_ACTION, 16'h00A5, "oc readback");
    wr(`CMD_RETRY_IVL, 8'h04);
    rdchk(`CMD_RETRY_IVL, 16'h0004, "retry interval");
    $display("test registers done");
    wr(`CMD_UV_ACTION, 8'hC0);
    rdbit(`CMD_STATUS_BYTE, `SB_CML_BIT, 1'b1, "bad response flag");
    rdchk(`CMD_UV_ACTION, 16'h0000, "bad response dropped");
    clr();
    rdbit(`CMD_STATUS_BYTE, `SB_CML_BIT, 1'b0, "flag cleared");
    i_host.write(`CMD_UV_ACTION, 8'h80, 3'h2);
    rdbit(`CMD_STATUS_BYTE, `SB_CML_BIT, 1'b1, "two data bytes");
    rdchk(`CMD_UV_ACTION, 16'h0000, "two bytes dropped");
    clr();
    $display("test refused writes done");
    uv_detect = 1'b1;
    cyc(12);
    chk(word_t'(output_enable), 16'h0001, "ignore keeps running");
    chk(word_t'(alert_oe), 16'h0001, "alert on fault");
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b1, "uv bit");
    rdbit(`CMD_STATUS_WORD, `SW_VOUT_BIT, 1'b1, "vout bit");
    uv_detect = 1'b0;
    cyc(20);
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b1, "uv bit latched");
    clr();
    chk(word_t'(alert_oe), 16'h0000, "alert released");
    $display("test ignore response done");
    chan_active = 1'b0;
    uv_detect = 1'b1;
    cyc(12);
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b0, "inactive masked");
    {chan_active, rise_active} = 2'b11;
    cyc(12);
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b0, "rise masked");
    {rise_active, fall_active} = 2'b01;
    cyc(12);
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b0, "fall masked");
    {uv_detect, fall_active} = 2'b00;
    cyc(8);
    $display("test masking done");
    wr(`CMD_UV_ACTION, 8'h80);
    uv_detect = 1'b1;
    wait_oe(1'b0, 12);
    uv_detect = 1'b0;
    cyc(150);
    chk(word_t'(output_enable), 16'h0000, "no restart");
    restart(1'b1);
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b0, "off on clears");
    $display("test shutdown done");
    wr(`CMD_UV_ACTION, 8'hB8);
    uv_detect = 1'b1;
    wait_oe(1'b0, 12);
    uv_detect = 1'b0;
    cyc(2 * TICK);
    chk(word_t'(output_enable), 16'h0000, "retry waits interval");
    wait_oe(1'b1, 12 * TICK + 20);
    uv_detect = 1'b1;
    wait_oe(1'b0, 12);
    {uv_detect, ton_max_fault} = 2'b01;
    cyc(1);
    ton_max_fault = 1'b0;
    cyc(150);
    chk(word_t'(output_enable), 16'h0000, "timeout stops retry");
    chk(word_t'(alert_oe), 16'h0001, "timeout alert");
    rdbit(`CMD_STATUS_BYTE, `SB_NONE_BIT, 1'b1, "none bit");
    rdbit(`CMD_STATUS_WORD, `SW_VOUT_BIT, 1'b1, "timeout vout");
    rdbit(`CMD_STATUS_VOUT, `SV_TON_BIT, 1'b1, "timeout bit");
    clr();
    restart(1'b0);
    $display("test retry done");
    wr(`CMD_UV_ACTION, 8'h47);
    uv_detect = 1'b1;
    cyc(8);
    chk(word_t'(uv_state), word_t'(UV_DEGLITCH), "deglitch state");
    uv_detect = 1'b0;
    cyc(8 * TICK + 10);
    chk(word_t'(output_enable), 16'h0001, "glitch ignored");
    wr(`CMD_UV_ACTION, 8'h43);
    uv_detect = 1'b1;
    cyc(4 + TICK);
    chk(word_t'(output_enable), 16'h0001, "still in delay");
    wait_oe(1'b0, 3 * TICK + 8);
    uv_detect = 1'b0;
    clr();
    restart(1'b0);
    $display("test deglitch done");
    wr(`CMD_TON_ACTION, 8'h00);
    ton_max_fault = 1'b1;
    cyc(1);
    ton_max_fault = 1'b0;
    cyc(10);
    chk(word_t'(output_enable), 16'h0001, "timeout disabled");
    rdbit(`CMD_STATUS_VOUT, `SV_TON_BIT, 1'b0, "no timeout bit");
    wr(`CMD_ALERT_MASK, 8'h01);
    wr(`CMD_UV_ACTION, 8'h00);
    uv_detect = 1'b1;
    cyc(12);
    chk(word_t'(alert_oe), 16'h0000, "alert masked");
    rdbit(`CMD_STATUS_VOUT, `SV_UV_BIT, 1'b1, "masked still flags");
    uv_detect = 1'b0;
    clr();
    $display("test timeout and mask done");
    print_verdict();
  end
endmodule
